// ### design/fpp_core.sv
// Fault protection and propagation of one point-of-load unit: trip detectors, shutdown
// style, retry timer and the open-drain group fault line. Sense words are synchronous.
`timescale 1ns/1ps
`include "fpp_defs.svh"
module fpp_core #(
    parameter int unsigned RETRY_CYC = `FPP_RETRY_CYC
) (
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire fpp_pkg::fpp_sense_t sense,
    input  wire logic               oc_fault,
    input  wire logic               uv_fault,
    input  wire logic [7:0]         ov_pct,
    input  wire logic               prop_wr,
    input  wire logic [7:0]         prop_wdata,
    output logic [7:0]              prop_rdata,
    input  wire logic               latch_wr,
    input  wire logic [7:0]         latch_wdata,
    input  wire logic               flags_clr,
    output logic [4:0]              condition_flags_n,
    input  wire logic               group_in,
    output logic                    group_out,
    output logic                    group_oe,
    output fpp_pkg::fpp_drive_t     drive
);
    logic [7:0]  prop_q, prop_d, latch_q, latch_d;
    logic [4:0]  flag_q, flag_d;
    logic [2:0]  gsync_q;
    logic        gbit_q, gbit_d, own_q, own_d, stop_q, stop_d, err_q, err_d, ext_q, ext_d;
    logic        armed_q, armed_d;
    logic [31:0] tmr_q, tmr_d;
    logic [11:0] ov_thr;
    logic [19:0] ov_prod;
    logic [7:0]  pct;
    logic [12:0] dev;
    logic        t_ot, t_tr, t_ov, hold_ot, cause, perr, pfault;

    // Percentage clipped to the programmable span
    always_comb begin
        pct = ov_pct;
        if (ov_pct < `FPP_OV_PCT_MIN) pct = `FPP_OV_PCT_MIN;
        if (ov_pct > `FPP_OV_PCT_MAX) pct = `FPP_OV_PCT_MAX;
        // Widen before the product so 130 percent of a large setpoint cannot wrap
        ov_prod = 20'(sense.setpoint_mv) * 20'(pct) / 20'h00064;
        if (ov_prod < 20'(`FPP_OV_FLOOR_MV))
            ov_thr = `FPP_OV_FLOOR_MV;
        else if (ov_prod > 20'h00FFF)
            ov_thr = 12'hFFF;
        else
            ov_thr = ov_prod[11:0];
        dev = (sense.vout_mv > sense.ramp_mv) ? 13'(sense.vout_mv - sense.ramp_mv)
                                              : 13'(sense.ramp_mv - sense.vout_mv);
        t_ot = sense.temp_c > `FPP_OT_TRIP_C;
        t_tr = sense.ramping_up && latch_q[`FPP_BIT_RAMP_EN]
               && (dev > 13'(`FPP_RAMP_DEV_MV));
        t_ov = armed_q && (sense.vout_mv > ov_thr);
        hold_ot = sense.temp_c >= `FPP_OT_RESTART_C;
        // Phase voltage error has no source in this variant
        perr   = t_ov && prop_q[`FPP_BIT_OV];
        pfault = (t_tr && prop_q[`FPP_BIT_RAMP]) || (t_ot && prop_q[`FPP_BIT_OT])
                 || (oc_fault && prop_q[`FPP_BIT_OC]) || (uv_fault && prop_q[`FPP_BIT_UV]);
        cause = t_ot || t_tr || t_ov || oc_fault || uv_fault;
    end

    always_comb begin
        prop_d  = prop_wr ? prop_wdata : prop_q;
        latch_d = latch_wr ? latch_wdata : latch_q;
        // Set wins over software clear
        flag_d  = flags_clr ? 5'h1F : flag_q;
        if (t_ot)     flag_d[4] = 1'b0;
        if (t_tr)     flag_d[3] = 1'b0;
        if (t_ov)     flag_d[2] = 1'b0;
        if (oc_fault) flag_d[1] = 1'b0;
        if (uv_fault) flag_d[0] = 1'b0;
        armed_d = (sense.vout_mv > sense.prebias_mv) || (armed_q && stop_q == 1'b0);
        gbit_d  = (gsync_q[1] == gsync_q[2]) ? gsync_q[1] : gbit_q;
        own_d   = own_q;
        if (perr || pfault) own_d = 1'b1;
        else if (!cause)    own_d = 1'b0;
        stop_d = stop_q;
        err_d  = err_q;
        ext_d  = ext_q;
        tmr_d  = tmr_q;
        if (cause) begin
            stop_d = 1'b1;
            err_d  = t_ov || t_tr || oc_fault;
            tmr_d  = RETRY_CYC;
        end else if (!gbit_q && !own_q) begin
            stop_d = 1'b1;
            ext_d  = 1'b1;
            tmr_d  = RETRY_CYC;
        end else if (stop_q) begin
            if (tmr_q != 32'h0000_0000) tmr_d = tmr_q - 32'h0000_0001;
            else if (!(ext_q ? 1'b0 : (latch_q[`FPP_BIT_OT] || hold_ot))) begin
                stop_d = 1'b0;
                err_d  = 1'b0;
                ext_d  = 1'b0;
            end
        end
        if (!gbit_q && !own_q && !stop_q) armed_d = 1'b0;
        if (!gbit_q && !own_q && !cause && stop_q) ext_d = 1'b1;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prop_q  <= `FPP_PROP_RESET;
            latch_q <= `FPP_LATCH_RESET;
            flag_q  <= 5'h1F;
            gsync_q <= 3'h7;
            gbit_q  <= 1'b1;
            own_q   <= 1'b0;
            stop_q  <= 1'b0;
            err_q   <= 1'b0;
            ext_q   <= 1'b0;
            armed_q <= 1'b0;
            tmr_q   <= 32'h0000_0000;
        end else begin
            prop_q  <= prop_d;
            latch_q <= latch_d;
            flag_q  <= flag_d;
            gsync_q <= {gsync_q[1:0], group_in};
            gbit_q  <= gbit_d;
            own_q   <= own_d;
            stop_q  <= stop_d;
            err_q   <= err_d;
            ext_q   <= ext_d;
            armed_q <= armed_d;
            tmr_q   <= tmr_d;
        end
    end

    // Open drain: only ever drives low, any of up to 32 members can hold it
    assign group_out         = 1'b0;
    assign group_oe          = own_q;
    assign prop_rdata        = prop_q;
    assign condition_flags_n = flag_q;
    // Error shutdowns keep the low side on while the overvoltage flag is latched, otherwise turn both sides off; all other shutdowns ramp down
    always_comb begin
        drive.high_side_on = !stop_q;
        drive.low_side_on  = !stop_q || (err_q && !flag_q[2]);
        drive.ramp_down    = stop_q && !err_q;
    end

    chk_ot_flag_clear: assert property (@(posedge mclk) disable iff (!resetn)
        t_ot |=> !condition_flags_n[4] && stop_q) else $error("overheat not latched");
    chk_ramp_only_up: assert property (@(posedge mclk) disable iff (!resetn)
        !sense.ramping_up |-> !t_tr) else $error("ramp check outside ramp-up");
    chk_ramp_fast_off: assert property (@(posedge mclk) disable iff (!resetn)
        t_tr |=> !drive.high_side_on && !drive.low_side_on) else $error("ramp not fast off");
    chk_ramp_disabled: assert property (@(posedge mclk) disable iff (!resetn)
        !latch_q[`FPP_BIT_RAMP_EN] |-> !t_tr) else $error("disabled check fired");
    chk_ov_armed: assert property (@(posedge mclk) disable iff (!resetn)
        t_ov |-> armed_q) else $error("overvoltage unarmed trip");
    chk_ov_low_side: assert property (@(posedge mclk) disable iff (!resetn)
        t_ov |=> !drive.high_side_on && drive.low_side_on) else $error("ov switch state");
    chk_ov_floor: assert property (@(posedge mclk) disable iff (!resetn)
        ov_thr >= `FPP_OV_FLOOR_MV) else $error("ov threshold below floor");
    chk_prop_drive: assert property (@(posedge mclk) disable iff (!resetn)
        (t_ot && prop_q[`FPP_BIT_OT]) |=> group_oe) else $error("no propagation");
    chk_group_stop: assert property (@(posedge mclk) disable iff (!resetn)
        (!gbit_q && !own_q) |=> stop_q) else $error("group low ignored");
    chk_release: assert property (@(posedge mclk) disable iff (!resetn)
        (!cause && !perr && !pfault) |=> !group_oe) else $error("line not released");
endmodule : fpp_core

// ### include/fpp_defs.svh
// Constants of the fault protection and propagation block: offsets, fields, resets, timing.
// Assumes a 50 MHz controller clock; analog levels arrive as 12-bit millivolt/degree codes.
`ifndef FPP_DEFS_SVH
`define FPP_DEFS_SVH
`define FPP_CLK_MHZ          50
`define FPP_OT_TRIP_C        12'h082
`define FPP_OT_RESTART_C     12'h078
`define FPP_RAMP_DEV_MV      12'h0FA
`define FPP_OV_FLOOR_MV      12'h3E8
`define FPP_OV_PCT_MIN       8'h6E
`define FPP_OV_PCT_MAX       8'h82
`define FPP_RETRY_MS         130
`define FPP_RETRY_CYC        (`FPP_RETRY_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_PROP_RESET       8'h3F
`define FPP_LATCH_RESET      8'h43
`define FPP_BIT_RAMP_EN      7
`define FPP_BIT_RAMP         5
`define FPP_BIT_OT           4
`define FPP_BIT_OC           3
`define FPP_BIT_UV           2
`define FPP_BIT_OV           1
`define FPP_BIT_PV           0
`endif

// ### include/fpp_pkg.sv
// Types shared by the fault protection and propagation block.
// Assumes fpp_defs.svh is included by every user.
package fpp_pkg;
    typedef struct packed {
        logic [11:0] vout_mv;
        logic [11:0] ramp_mv;
        logic [11:0] setpoint_mv;
        logic [11:0] prebias_mv;
        logic [11:0] temp_c;
        logic        ramping_up;
    } fpp_sense_t;
    typedef struct packed {
        logic high_side_on;
        logic low_side_on;
        logic ramp_down;
    } fpp_drive_t;
    typedef enum logic [1:0] {FPP_NONE, FPP_FAULT, FPP_ERROR} fpp_kind_t;
endpackage : fpp_pkg

// ### verif/fpp_peer_model.sv
// Peer unit on the wired group fault line, able to pull it low on request.
// Assumes a pull-up on the line and the clock shared with the bench.
`timescale 1ns/1ps
module fpp_peer_model (
    input  wire logic mclk,
    input  wire logic pull_req,
    input  wire logic dut_oe,
    output logic      line
);
    logic pull_q;
    always_ff @(posedge mclk) begin
        pull_q <= pull_req;
    end
    // Wired-AND: the pull-up loses to any member driving low
    assign line = ~(dut_oe | pull_q);
endmodule : fpp_peer_model

// ### verif/fault_protection_propagation_test.sv
// Self-checking bench of fpp_core with one peer on the group fault line.
// Assumes the shortened retry count of 20 cycles.
`timescale 1ns/1ps
module fault_protection_propagation_test;
    logic                mclk = 1'b0;
    logic                resetn = 1'b0;
    fpp_pkg::fpp_sense_t sense;
    logic                prop_wr = 1'b0, latch_wr = 1'b0, peer_pull = 1'b0;
    logic [7:0]          prop_wdata = 8'h00, latch_wdata = 8'h43, ov_pct = 8'h6E;
    logic [7:0]          prop_rdata, v;
    logic [4:0]          flags_n;
    logic                group_in, group_oe;
    fpp_pkg::fpp_drive_t drive;
    int                  fail_count = 0, samples_checked = 0, seed = 85512, thr, i;
    always #10 mclk = ~mclk;
    fpp_core #(.RETRY_CYC(20)) dut_u (.mclk(mclk), .resetn(resetn), .sense(sense),
        .oc_fault(1'b0), .uv_fault(1'b0), .ov_pct(ov_pct), .prop_wr(prop_wr),
        .prop_wdata(prop_wdata), .prop_rdata(prop_rdata), .latch_wr(latch_wr),
        .latch_wdata(latch_wdata), .flags_clr(1'b0), .condition_flags_n(flags_n),
        .group_in(group_in), .group_out(), .group_oe(group_oe), .drive(drive));
    fpp_peer_model peer_u (.mclk(mclk), .pull_req(peer_pull), .dut_oe(group_oe),
        .line(group_in));
    function automatic int ov_mv(input int sp, input int pct);
        return (sp * pct / 100 < 1000) ? 1000 : sp * pct / 100;
    endfunction : ov_mv
    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic restart(input logic [11:0] sp);
        @(posedge mclk);
        resetn <= 1'b0;
        peer_pull <= 1'b0;
        sense <= '{sp, sp, sp, 12'h000, 12'h019 + 12'($unsigned($random(seed)) % 80), 1'b0};
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
    endtask : restart
    task automatic set_reg(input bit lat, input logic [7:0] d);
        @(posedge mclk);
        prop_wr <= !lat;
        latch_wr <= lat;
        prop_wdata <= d;
        latch_wdata <= d;
        @(posedge mclk);
        prop_wr <= 1'b0;
        latch_wr <= 1'b0;
    endtask : set_reg
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    task automatic stop_test;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        restart(12'h3E8);
        settle(1);
        cmp_byte(prop_rdata, 8'h3F);
        cmp_byte({3'h0, flags_n}, 8'h1F);
        v = 8'($random(seed));
        set_reg(0, v);
        #1;
        cmp_byte(prop_rdata, v);
        set_reg(0, 8'h10);
        sense.temp_c <= 12'h082;
        settle(4);
        cmp_bit(flags_n[4], 1'b1);
        sense.temp_c <= 12'h083;
        settle(3);
        cmp_bit(flags_n[4], 1'b0);
        cmp_bit(drive.ramp_down, 1'b1);
        cmp_bit(group_oe, 1'b1);
        sense.temp_c <= 12'h077;
        for (i = 0; i < 60 && group_oe !== 1'b0; i++) @(posedge mclk);
        cmp_bit(group_oe, 1'b0);
        if (group_oe !== 1'b0) stop_test();
        settle(25);
        cmp_bit(drive.high_side_on, 1'b1);
        for (int k = 0; k < 2; k++) begin
            restart(k ? 12'h3E8 : 12'h320);
            ov_pct <= 8'h6E + 8'($unsigned($random(seed)) % 21);
            set_reg(0, 8'h01);
            thr = ov_mv(k ? 1000 : 800, int'(ov_pct));
            sense.vout_mv <= 12'(thr);
            settle(4);
            cmp_bit(flags_n[2], 1'b1);
            sense.vout_mv <= 12'(thr + 1);
            settle(3);
            cmp_bit(flags_n[2], 1'b0);
            cmp_bit(drive.high_side_on, 1'b0);
            cmp_bit(drive.low_side_on, 1'b1);
            cmp_bit(group_oe, 1'b0);
        end
        restart(12'h3E8);
        sense.ramp_mv <= 12'h2ED;
        sense.ramping_up <= 1'b1;
        settle(4);
        cmp_bit(flags_n[3], 1'b1);
        sense.ramping_up <= 1'b0;
        set_reg(1, 8'hC3);
        settle(3);
        cmp_bit(flags_n[3], 1'b1);
        sense.ramping_up <= 1'b1;
        settle(3);
        cmp_bit(flags_n[3], 1'b0);
        cmp_bit(drive.low_side_on, 1'b0);
        restart(12'h3E8);
        settle(3);
        peer_pull <= 1'b1;
        settle(8);
        cmp_bit(drive.high_side_on, 1'b0);
        stop_test();
    end
endmodule : fault_protection_propagation_test
